/* core/iasr_pkg.sv */
package iasr_pkg;

	// ---------------------------------------------------------------
	// Widths and timing
	// ---------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int SEL_W = 4;
	localparam int NBANK = 5;
	localparam int CLK_MHZ = 100;
	localparam int RATE_WIN_NS = 1000;
	localparam int RATE_CNT_W = 16;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_RATE = 8'hA5;
	localparam logic [7:0] ADR_RSV_LO = 8'hA7;
	localparam logic [7:0] ADR_RSV_HI = 8'hAF;
	localparam logic [7:0] ADR_CTL = 8'hB0;
	localparam logic [7:0] ADR_OFS = 8'hB1;
	localparam logic [7:0] ADR_WIN = 8'hB2;
	localparam logic [7:0] ADR_BIST = 8'hB3;
	localparam logic [7:0] ADR_B4 = 8'hB4;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_OFS = 8'h01;
	localparam logic [7:0] RST_WIN = 8'h00;
	localparam logic [7:0] RST_BIST = 8'h08;
	localparam logic [7:0] RST_B4 = 8'h25;
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTL_SEL_MSB = 5;
	localparam int CTL_SEL_LSB = 2;
	localparam int CTL_AUTO_BIT = 1;
	localparam int CTL_READ_BIT = 0;
	localparam logic [7:0] CTL_WMASK = 8'h3F;
	localparam int BST_MODE_MSB = 7;
	localparam int BST_MODE_LSB = 6;
	localparam int BST_PIN_BIT = 3;
	localparam int BST_SRC_MSB = 2;
	localparam int BST_SRC_LSB = 1;
	localparam int BST_EN_BIT = 0;

	// ---------------------------------------------------------------
	// Target codes and bank strobes
	// ---------------------------------------------------------------
	localparam logic [3:0] SEL_PG = 4'h0;
	localparam logic [3:0] SEL_RX0 = 4'h1;
	localparam logic [3:0] SEL_RX1 = 4'h2;
	localparam logic [3:0] SEL_SHARED = 4'h5;
	localparam logic [3:0] SEL_BOTH = 4'h6;
	localparam logic [3:0] SEL_CSI = 4'h7;
	localparam logic [4:0] MASK_NONE = 5'h00;
	localparam logic [4:0] MASK_PG = 5'h01;
	localparam logic [4:0] MASK_RX0 = 5'h02;
	localparam logic [4:0] MASK_RX1 = 5'h04;
	localparam logic [4:0] MASK_SHARED = 5'h08;
	localparam logic [4:0] MASK_CSI = 5'h10;
	localparam logic [4:0] MASK_BOTH = 5'h06;

	localparam logic [1:0] OUT_MODE_ON = 2'h2;
	localparam logic [7:0] SER_CLKSRC_OFS = 8'h14;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_PUSH = 3'h2,
		ST_RUN = 3'h4
	} iasr_bist_state_t;

endpackage

/* core/iasr_rate_meter.sv */
`timescale 1ns/1ps
module iasr_rate_meter #(
	parameter int CLK_MHZ = iasr_pkg::CLK_MHZ,
	parameter int WIN_NS = iasr_pkg::RATE_WIN_NS
) (
	// Clock and control
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	// Measured clock, sampled as a level
	input wire logic ref_in,
	// Result in whole MHz
	output logic [iasr_pkg::DATA_W-1:0] rate
);
	import iasr_pkg::*;

	localparam int WIN_CYC_I = (WIN_NS * CLK_MHZ) / 1000;
	localparam logic [RATE_CNT_W-1:0] WIN_LAST = RATE_CNT_W'(WIN_CYC_I - 1);
	localparam logic [DATA_W-1:0] SAT = 8'hFF;

	logic [RATE_CNT_W-1:0] win_q;
	logic [DATA_W-1:0] edges_q;
	logic [DATA_W-1:0] rate_q;
	logic ref_prev_q;
	wire rise = ref_in & ~ref_prev_q;
	wire win_end = (win_q == WIN_LAST);
	wire [DATA_W-1:0] edges_inc = (edges_q == SAT) ? SAT : DATA_W'(edges_q + ONE_BYTE);
	wire [DATA_W-1:0] edges_now = rise ? edges_inc : edges_q;

	// Edges per microsecond, updated freely at each window end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			win_q <= '0;
			edges_q <= ZERO_BYTE;
			rate_q <= RST_RATE;
			ref_prev_q <= 1'b0;
		end else if (ce) begin
			ref_prev_q <= ref_in;
			win_q <= win_end ? '0 : RATE_CNT_W'(win_q + 1'b1);
			edges_q <= win_end ? ZERO_BYTE : edges_now;
			if (win_end) begin
				rate_q <= edges_now;
			end
		end
	end

	assign rate = rate_q;

endmodule

/* core/iasr_regs.sv */
`timescale 1ns/1ps
module iasr_regs (
	// Clock and control
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	// Register port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [iasr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [iasr_pkg::DATA_W-1:0] reg_wdata,
	output logic [iasr_pkg::DATA_W-1:0] reg_rdata,
	// Reference clock sampled as a level
	input wire logic reference_clock_input,
	// Indirect bank port
	output logic [iasr_pkg::NBANK-1:0] bank_wr_stb,
	output logic [iasr_pkg::NBANK-1:0] bank_prefetch_stb,
	output logic [iasr_pkg::DATA_W-1:0] bank_offset,
	output logic [iasr_pkg::DATA_W-1:0] bank_wdata,
	input wire logic [iasr_pkg::DATA_W-1:0] pg_rdata,
	input wire logic [iasr_pkg::DATA_W-1:0] rx0_rdata,
	input wire logic [iasr_pkg::DATA_W-1:0] rx1_rdata,
	input wire logic [iasr_pkg::DATA_W-1:0] shared_rdata,
	input wire logic [iasr_pkg::DATA_W-1:0] csi_rdata,
	// Self-test
	input wire logic self_test_pin,
	output logic self_test_active,
	output logic self_test_out_en,
	// Serializer clock source push
	output logic ser_wr_req,
	input wire logic ser_wr_ack,
	output logic [iasr_pkg::DATA_W-1:0] ser_wr_offset,
	output logic [1:0] ser_wr_data
);
	import iasr_pkg::*;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] ctl_q;
	logic [DATA_W-1:0] ofs_q;
	logic [DATA_W-1:0] ofs_d;
	logic [DATA_W-1:0] win_q;
	logic [DATA_W-1:0] bist_q;
	logic [DATA_W-1:0] b4_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [NBANK-1:0] wr_stb_q;
	logic [NBANK-1:0] pf_stb_q;
	logic wr_done_q;
	logic [1:0] src_q;
	iasr_bist_state_t st_q;
	iasr_bist_state_t st_d;
	logic [DATA_W-1:0] rate;

	iasr_rate_meter #(
		.CLK_MHZ(CLK_MHZ),
		.WIN_NS(RATE_WIN_NS)
	) u_rate (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.ref_in(reference_clock_input),
		.rate(rate)
	);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	wire hit_ctl = (reg_addr == ADR_CTL);
	wire hit_ofs = (reg_addr == ADR_OFS);
	wire hit_win = (reg_addr == ADR_WIN);
	wire hit_bist = (reg_addr == ADR_BIST);
	wire hit_b4 = (reg_addr == ADR_B4);
	wire wr_ctl = ce & reg_wr_en & hit_ctl;
	wire wr_ofs = ce & reg_wr_en & hit_ofs;
	wire wr_win = ce & reg_wr_en & hit_win;
	wire rd_win = ce & reg_rd_en & hit_win;

	wire [SEL_W-1:0] indirect_target_select = ctl_q[CTL_SEL_MSB:CTL_SEL_LSB];
	wire indirect_offset_autostep = ctl_q[CTL_AUTO_BIT];
	wire indirect_prefetch_strobe = ctl_q[CTL_READ_BIT];

	// Single bank targets, used for reads and prefetch
	wire [NBANK-1:0] rd_mask;
	assign rd_mask = (indirect_target_select == SEL_PG) ? MASK_PG :
		(indirect_target_select == SEL_RX0) ? MASK_RX0 :
		(indirect_target_select == SEL_RX1) ? MASK_RX1 :
		(indirect_target_select == SEL_SHARED) ? MASK_SHARED :
		(indirect_target_select == SEL_CSI) ? MASK_CSI : MASK_NONE;
	// Writes also accept the dual receive port code
	wire [NBANK-1:0] wr_mask;
	assign wr_mask = (indirect_target_select == SEL_BOTH) ? MASK_BOTH : rd_mask;

	// Reserved targets read as zero
	wire [DATA_W-1:0] indirect_window_value;
	assign indirect_window_value = (rd_mask == MASK_PG) ? pg_rdata :
		(rd_mask == MASK_RX0) ? rx0_rdata :
		(rd_mask == MASK_RX1) ? rx1_rdata :
		(rd_mask == MASK_SHARED) ? shared_rdata :
		(rd_mask == MASK_CSI) ? csi_rdata : ZERO_BYTE;

	wire in_rsv_range = (reg_addr >= ADR_RSV_LO) && (reg_addr <= ADR_RSV_HI);
	always_comb begin
		if (reg_addr == ADR_RATE) begin
			rdata_d = rate;
		end else if (hit_ctl) begin
			rdata_d = ctl_q & CTL_WMASK;
		end else if (hit_ofs) begin
			rdata_d = ofs_q;
		end else if (hit_win) begin
			rdata_d = indirect_window_value;
		end else if (hit_bist) begin
			rdata_d = bist_q;
		end else if (hit_b4) begin
			rdata_d = b4_q;
		end else if (in_rsv_range) begin
			rdata_d = ZERO_BYTE;
		end else begin
			rdata_d = ZERO_BYTE;
		end
	end

	// ---------------------------------------------------------------
	// Indirect offset and strobes
	// ---------------------------------------------------------------
	wire step = indirect_offset_autostep & (wr_done_q | rd_win);
	wire [DATA_W-1:0] indirect_offset_value = ofs_q;
	always_comb begin
		if (wr_ofs) begin
			ofs_d = reg_wdata;
		end else if (step) begin
			ofs_d = DATA_W'(ofs_q + ONE_BYTE);
		end else begin
			ofs_d = ofs_q;
		end
	end
	wire pf_fire = indirect_prefetch_strobe &
		(wr_ofs | (rd_win & indirect_offset_autostep));

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctl_q <= RST_CTL;
			ofs_q <= RST_OFS;
			win_q <= RST_WIN;
			b4_q <= RST_B4;
			rdata_q <= ZERO_BYTE;
			wr_stb_q <= MASK_NONE;
			pf_stb_q <= MASK_NONE;
			wr_done_q <= 1'b0;
		end else if (ce) begin
			ofs_q <= ofs_d;
			wr_done_q <= wr_win;
			wr_stb_q <= wr_win ? wr_mask : MASK_NONE;
			pf_stb_q <= pf_fire ? rd_mask : MASK_NONE;
			if (reg_rd_en) begin
				rdata_q <= rdata_d;
			end
			if (wr_ctl) begin
				ctl_q <= reg_wdata & CTL_WMASK;
			end
			if (wr_win) begin
				win_q <= reg_wdata;
			end
			if (reg_wr_en && hit_b4) begin
				b4_q <= reg_wdata;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign bank_wr_stb = wr_stb_q;
	assign bank_prefetch_stb = pf_stb_q;
	assign bank_offset = indirect_offset_value;
	assign bank_wdata = win_q;

	// ---------------------------------------------------------------
	// Self-test control
	// ---------------------------------------------------------------
	wire [1:0] out_mode = bist_q[BST_MODE_MSB:BST_MODE_LSB];
	wire st_enable = bist_q[BST_PIN_BIT] ? self_test_pin : bist_q[BST_EN_BIT];

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (st_enable) begin
					st_d = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (!st_enable) begin
					st_d = ST_IDLE;
				end else if (ser_wr_ack) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!st_enable) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bist_q <= RST_BIST;
			st_q <= ST_IDLE;
			src_q <= 2'h0;
		end else if (ce) begin
			st_q <= st_d;
			if (reg_wr_en && hit_bist) begin
				bist_q <= reg_wdata;
			end
			if (st_q == ST_IDLE && st_enable) begin
				src_q <= bist_q[BST_SRC_MSB:BST_SRC_LSB];
			end
		end
	end

	assign self_test_active = (st_q != ST_IDLE);
	// Reserved modes treated as outputs off
	assign self_test_out_en = !self_test_active || (out_mode == OUT_MODE_ON);
	assign ser_wr_req = (st_q == ST_PUSH);
	assign ser_wr_offset = SER_CLKSRC_OFS;
	assign ser_wr_data = src_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst || !ce);

	sequence s_win_write(logic [3:0] code);
		wr_win && indirect_target_select == code;
	endsequence

	sequence s_pf_read;
		rd_win && indirect_offset_autostep && indirect_prefetch_strobe && !wr_ofs;
	endsequence

	a_rate_readback: assert property (reg_rd_en && reg_addr == ADR_RATE |=>
		reg_rdata == $past(rate)) else $error("rate readback mismatch");
	a_sel_route: assert property (s_win_write(SEL_RX1) |=>
		bank_wr_stb == MASK_RX1) else $error("target route wrong");
	a_both_ports: assert property (s_win_write(SEL_BOTH) |=>
		bank_wr_stb == MASK_BOTH) else $error("dual port write missing");
	a_step_read: assert property (rd_win && indirect_offset_autostep && !wr_ofs |=>
		bank_offset == DATA_W'($past(bank_offset) + ONE_BYTE)) else $error("no step");
	a_step_write: assert property (wr_win && indirect_offset_autostep ##1 !wr_ofs |=>
		bank_offset == DATA_W'($past(bank_offset, 2) + ONE_BYTE)) else $error("no step");
	a_prefetch_offset: assert property (wr_ofs && indirect_prefetch_strobe |=>
		bank_prefetch_stb == $past(rd_mask) && bank_offset == $past(reg_wdata))
		else $error("prefetch on offset write wrong");
	a_prefetch_next: assert property (s_pf_read |=>
		bank_prefetch_stb == $past(rd_mask) &&
		bank_offset == DATA_W'($past(bank_offset) + ONE_BYTE)) else $error("next prefetch wrong");
	a_offset_hold: assert property (!wr_ofs && !step |=> $stable(bank_offset))
		else $error("offset moved");
	a_window_write: assert property (wr_win |=> bank_wdata == $past(reg_wdata) &&
		bank_offset == $past(bank_offset)) else $error("window write wrong");
	a_window_read: assert property (reg_rd_en && hit_win |=>
		reg_rdata == $past(indirect_window_value)) else $error("window read wrong");
	a_out_mode: assert property (self_test_active && out_mode == 2'h0 |->
		!self_test_out_en) else $error("outputs not disabled");
	a_pin_select: assert property (st_q == ST_IDLE && bist_q[BST_PIN_BIT] &&
		!self_test_pin |=> st_q == ST_IDLE) else $error("pin mode ignored");
	a_clock_push: assert property (st_q == ST_IDLE && st_enable |=>
		ser_wr_req && ser_wr_data == $past(bist_q[BST_SRC_MSB:BST_SRC_LSB]))
		else $error("clock source push missing");
	a_run_stop: assert property (self_test_active && !st_enable |=>
		!self_test_active) else $error("self-test did not stop");
	a_reserved_quiet: assert property (wr_win && wr_mask == MASK_NONE |=>
		bank_wr_stb == MASK_NONE ##0 bank_prefetch_stb == MASK_NONE)
		else $error("reserved target touched");

	// ---------------------------------------------------------------
	// Routing, strobe causes and self-test handshake
	// ---------------------------------------------------------------
	sequence s_push_wait;
		ser_wr_req && !ser_wr_ack && st_enable;
	endsequence

	sequence s_reg_idle;
		st_q == ST_IDLE && !bist_q[BST_PIN_BIT] && !bist_q[BST_EN_BIT];
	endsequence

	a_sel_pg: assert property (s_win_write(SEL_PG) |=>
		bank_wr_stb == MASK_PG) else $error("pattern bank route wrong");
	a_sel_rx0: assert property (s_win_write(SEL_RX0) |=>
		bank_wr_stb == MASK_RX0) else $error("port 0 route wrong");
	a_sel_shared: assert property (s_win_write(SEL_SHARED) |=>
		bank_wr_stb == MASK_SHARED) else $error("shared bank route wrong");
	a_sel_csi: assert property (s_win_write(SEL_CSI) |=>
		bank_wr_stb == MASK_CSI) else $error("output bank route wrong");
	a_ctl_reserved: assert property (reg_rd_en && hit_ctl |=>
		reg_rdata[DATA_W-1:CTL_SEL_MSB+1] == '0) else $error("control top bits not zero");
	a_reserved_read: assert property (rd_win && rd_mask == MASK_NONE |=>
		reg_rdata == ZERO_BYTE) else $error("reserved target read not zero");
	a_wr_cause: assert property (!wr_win |=>
		bank_wr_stb == MASK_NONE) else $error("write strobe without window write");
	a_win_hold: assert property (!wr_win |=>
		$stable(bank_wdata)) else $error("window data moved");
	a_pf_cause: assert property (!wr_ofs && !rd_win |=>
		bank_prefetch_stb == MASK_NONE) else $error("prefetch strobe without cause");
	a_ofs_write: assert property (wr_ofs |=>
		bank_offset == $past(reg_wdata)) else $error("offset write lost");
	a_ofs_readback: assert property (reg_rd_en && hit_ofs |=>
		reg_rdata == $past(bank_offset)) else $error("offset readback wrong");
	a_push_hold: assert property (s_push_wait |=>
		ser_wr_req && $stable(ser_wr_data)) else $error("serializer push dropped");
	a_push_done: assert property (ser_wr_req && ser_wr_ack |=>
		!ser_wr_req) else $error("serializer push not ended");
	a_idle_out: assert property (!self_test_active |->
		self_test_out_en) else $error("outputs off outside self-test");
	a_mode_on: assert property (self_test_active && out_mode == OUT_MODE_ON |->
		self_test_out_en) else $error("outputs not kept on");
	a_reg_idle: assert property (s_reg_idle |=>
		st_q == ST_IDLE) else $error("register mode ignored");
	a_state_onehot: assert property ($onehot(st_q))
		else $error("self-test state not one-hot");

endmodule

/* verif/iasr_far_model.sv */
`timescale 1ns/1ps
module iasr_far_model (
	// Clock and reset
	sys_clk,
	srst,
	// Bank side
	bank_wr_stb,
	bank_offset,
	bank_wdata,
	pg_rdata,
	rx0_rdata,
	rx1_rdata,
	shared_rdata,
	csi_rdata,
	// Serializer side
	ser_wr_req,
	ser_wr_offset,
	ser_wr_data,
	ser_wr_ack,
	ack_delay,
	ser_clk_source
);
	import iasr_pkg::*;
	input wire logic sys_clk;
	input wire logic srst;
	input wire logic [iasr_pkg::NBANK-1:0] bank_wr_stb;
	input wire logic [iasr_pkg::DATA_W-1:0] bank_offset;
	input wire logic [iasr_pkg::DATA_W-1:0] bank_wdata;
	output logic [iasr_pkg::DATA_W-1:0] pg_rdata;
	output logic [iasr_pkg::DATA_W-1:0] rx0_rdata;
	output logic [iasr_pkg::DATA_W-1:0] rx1_rdata;
	output logic [iasr_pkg::DATA_W-1:0] shared_rdata;
	output logic [iasr_pkg::DATA_W-1:0] csi_rdata;
	input wire logic ser_wr_req;
	input wire logic [iasr_pkg::DATA_W-1:0] ser_wr_offset;
	input wire logic [1:0] ser_wr_data;
	output logic ser_wr_ack;
	input wire logic [3:0] ack_delay;
	output logic [1:0] ser_clk_source;

	logic [7:0] mem [NBANK][256];
	logic [3:0] cnt_q;

	// -----------------------------------------------------------
	// Bank storage, preloaded with a known pattern
	// -----------------------------------------------------------
	initial begin
		for (int b = 0; b < NBANK; b++) begin
			for (int o = 0; o < 256; o++) begin
				mem[b][o] = 8'((o * 3) + (b * 17));
			end
		end
	end
	always @(posedge sys_clk) begin
		for (int b = 0; b < NBANK; b++) begin
			if (bank_wr_stb[b]) begin
				mem[b][bank_offset] <= bank_wdata;
			end
		end
	end
	assign pg_rdata = mem[0][bank_offset];
	assign rx0_rdata = mem[1][bank_offset];
	assign rx1_rdata = mem[2][bank_offset];
	assign shared_rdata = mem[3][bank_offset];
	assign csi_rdata = mem[4][bank_offset];

	// -----------------------------------------------------------
	// Serializer: ack after a chosen delay, keep clock source
	// -----------------------------------------------------------
	always @(posedge sys_clk) begin
		if (srst || ser_wr_ack || !ser_wr_req) begin
			ser_wr_ack <= 1'b0;
			cnt_q <= 4'h0;
		end else if (cnt_q == ack_delay) begin
			ser_wr_ack <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
		if (srst) begin
			ser_clk_source <= 2'h0;
		end else if (ser_wr_ack && ser_wr_offset == SER_CLKSRC_OFS) begin
			ser_clk_source <= ser_wr_data;
		end
	end
endmodule

/* verif/tb_indirect_access_selftest_regs.sv */
`timescale 1ns/1ps
module tb_indirect_access_selftest_regs;
	import iasr_pkg::*;
	logic sys_clk, srst, ce, reg_wr_en, reg_rd_en, ref_in, st_pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, bank_offset, bank_wdata, ser_ofs, rd_v;
	logic [7:0] pg_rd, rx0_rd, rx1_rd, sh_rd, csi_rd;
	logic [4:0] wr_stb, pf_stb;
	logic st_active, st_out_en, ser_wr_req, ser_wr_ack;
	logic [1:0] ser_wr_data, ser_src;
	logic [3:0] ack_delay;
	logic [3:0] ph = 4'h0;
	int num_errors, n_checks, cycles;
	int mem_m [5][256];

	iasr_regs u_dut (.sys_clk(sys_clk), .srst(srst), .ce(ce), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reference_clock_input(ref_in), .bank_wr_stb(wr_stb),
		.bank_prefetch_stb(pf_stb), .bank_offset(bank_offset), .bank_wdata(bank_wdata),
		.pg_rdata(pg_rd), .rx0_rdata(rx0_rd), .rx1_rdata(rx1_rd), .shared_rdata(sh_rd),
		.csi_rdata(csi_rd), .self_test_pin(st_pin), .self_test_active(st_active),
		.self_test_out_en(st_out_en), .ser_wr_req(ser_wr_req), .ser_wr_ack(ser_wr_ack),
		.ser_wr_offset(ser_ofs), .ser_wr_data(ser_wr_data));
	iasr_far_model u_far (.sys_clk(sys_clk), .srst(srst), .bank_wr_stb(wr_stb),
		.bank_offset(bank_offset), .bank_wdata(bank_wdata), .pg_rdata(pg_rd),
		.rx0_rdata(rx0_rd), .rx1_rdata(rx1_rd), .shared_rdata(sh_rd), .csi_rdata(csi_rd),
		.ser_wr_req(ser_wr_req), .ser_wr_offset(ser_ofs), .ser_wr_data(ser_wr_data),
		.ser_wr_ack(ser_wr_ack), .ack_delay(ack_delay), .ser_clk_source(ser_src));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Reference clock at a quarter of the system clock
	always @(negedge sys_clk) begin
		ph <= ph + 4'h1;
		ref_in <= ph[1];
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		repeat (2) @(negedge sys_clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		repeat (2) @(negedge sys_clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd_en = 1'b0;
		rd_v = reg_rdata;
	endtask
	task automatic req_done();
		for (int i = 0; i < 20 && ser_wr_req !== 1'b0; i++) @(negedge sys_clk);
		chk("ser_req", ser_wr_req, 8'h00);
	endtask
	function automatic int idx_of(logic [3:0] c);
		case (c)
			4'h0: return 0;
			4'h1: return 1;
			4'h2: return 2;
			4'h5: return 3;
			4'h7: return 4;
			default: return -1;
		endcase
	endfunction

	initial begin
		int k;
		logic [7:0] o, d, o6, b;
		logic [4:0] m;
		{ce, srst, reg_wr_en, reg_rd_en, st_pin} = 5'h18;
		{reg_addr, reg_wdata, ack_delay} = 20'h00000;
		void'($urandom(32'h1E29));
		for (int i = 0; i < 5; i++) for (int j = 0; j < 256; j++) mem_m[i][j] = (j * 3 + i * 17) % 256;
		repeat (6) @(negedge sys_clk);
		srst = 1'b0;
		// -----------------------------------------------------------
		// Reset values, reserved and unmapped places, clock enable
		// -----------------------------------------------------------
		rd(ADR_CTL); chk("ctl", rd_v, 8'h00);
		rd(ADR_OFS); chk("ofs", rd_v, 8'h01);
		rd(ADR_BIST); chk("bist", rd_v, 8'h08);
		rd(ADR_B4); chk("b4", rd_v, 8'h25);
		wr(ADR_RSV_LO, 8'h5A); rd(ADR_RSV_LO); chk("rsv", rd_v, 8'h00);
		wr(8'hC0, 8'h33); rd(8'hC0); chk("unmapped", rd_v, 8'h00);
		wr(ADR_CTL, 8'hFF); rd(ADR_CTL); chk("ctl_rw", rd_v, 8'h3F);
		ce = 1'b0; wr(ADR_OFS, 8'h77); ce = 1'b1;
		rd(ADR_OFS); chk("ce_hold", rd_v, 8'h01);
		$display("test reset done");
		// -----------------------------------------------------------
		// Rate: read until two reads agree
		// -----------------------------------------------------------
		repeat (250) @(negedge sys_clk);
		wr(ADR_RATE, 8'h00);
		rd(ADR_RATE); d = rd_v; rd(ADR_RATE);
		for (int i = 0; i < 4 && rd_v !== d; i++) begin
			d = rd_v; rd(ADR_RATE);
		end
		chk("rate", rd_v, 8'd25);
		$display("test rate done");
		// -----------------------------------------------------------
		// Every target code: write, strobe mask, read back
		// -----------------------------------------------------------
		for (int c = 0; c < 16; c++) begin
			k = idx_of(4'(c));
			m = (c == 6) ? 5'h06 : (k >= 0) ? 5'(1 << k) : 5'h00;
			o = 8'($urandom_range(255));
			d = 8'($urandom);
			if (c == 6) o6 = o;
			wr(ADR_CTL, {2'b00, 4'(c), 2'b00});
			wr(ADR_OFS, o); chk("no_prefetch", pf_stb, 8'h00);
			wr(ADR_WIN, d); chk("wr_stb", wr_stb, m);
			chk("wdata", bank_wdata, d);
			for (int i = 0; i < 5; i++) if (m[i]) mem_m[i][o] = d;
			rd(ADR_WIN); chk("window", rd_v, k >= 0 ? 8'(mem_m[k][o]) : 8'h00);
			chk("ofs_fixed", bank_offset, o);
		end
		for (int c = 1; c < 3; c++) begin
			wr(ADR_CTL, {2'b00, 4'(c), 2'b00}); wr(ADR_OFS, o6);
			rd(ADR_WIN); chk("both_ports", rd_v, 8'(mem_m[c][o6]));
		end
		$display("test targets done");
		// -----------------------------------------------------------
		// Auto-step with prefetch, across the offset wrap
		// -----------------------------------------------------------
		wr(ADR_CTL, 8'h17);
		wr(ADR_OFS, 8'hFE); chk("pf_ofs", pf_stb, MASK_SHARED);
		for (int i = 0; i < 3; i++) begin
			b = 8'(8'hFE + i);
			rd(ADR_WIN); chk("step_rd", rd_v, 8'(mem_m[3][b]));
			chk("pf_rd", pf_stb, MASK_SHARED);
			chk("step_ofs", bank_offset, b + 8'h01);
		end
		d = 8'($urandom);
		wr(ADR_WIN, d); @(negedge sys_clk);
		mem_m[3][1] = d;
		chk("step_wr", bank_offset, 8'h02);
		wr(ADR_CTL, 8'h15);
		rd(ADR_WIN); chk("no_step", bank_offset, 8'h02);
		chk("no_step_rd", rd_v, 8'(mem_m[3][2]));
		chk("no_pf", pf_stb, 8'h00);
		wr(ADR_CTL, 8'h00);
		$display("test autostep done");
		// -----------------------------------------------------------
		// Self-test from the pin, then from the register
		// -----------------------------------------------------------
		ack_delay = 4'($urandom_range(6));
		wr(ADR_BIST, 8'h0C);
		st_pin = 1'b1; repeat (2) @(negedge sys_clk);
		chk("pin_active", st_active, 8'h01);
		chk("pin_data", ser_wr_data, 8'h02);
		chk("ser_ofs", ser_ofs, SER_CLKSRC_OFS);
		chk("out_off", st_out_en, 8'h00);
		req_done(); chk("ser_src", ser_src, 8'h02);
		st_pin = 1'b0; repeat (2) @(negedge sys_clk);
		chk("pin_stop", st_active, 8'h00);
		for (int s = 0; s < 3; s++) begin
			ack_delay = 4'($urandom_range(6));
			m = (s == 0) ? 5'h02 : (s == 1) ? 5'h00 : 5'h03;
			wr(ADR_BIST, {m[1:0], 3'b000, 2'(s), 1'b1});
			st_pin = 1'b1; @(negedge sys_clk);
			chk("reg_active", st_active, 8'h01);
			chk("ser_data", ser_wr_data, 8'(s));
			chk("out_en", st_out_en, m == 5'h02);
			req_done(); chk("ser_src", ser_src, 8'(s));
			wr(ADR_BIST, {m[1:0], 3'b000, 2'(s), 1'b0}); @(negedge sys_clk);
			chk("reg_stop", st_active, 8'h00);
			chk("out_idle", st_out_en, 8'h01);
		end
		$display("test selftest done");
		final_report();
	end
endmodule
